// ===== pkg/dcc_pkg.sv
// package of register map, field positions and timing for the dual comparator control
`default_nettype none
package dcc_pkg;
   // register byte addresses
   localparam logic [15:0] ADDR_CH0_CONTROL   = 16'hf950;
   localparam logic [15:0] ADDR_CH0_INT_SETUP = 16'hf951;
   localparam logic [15:0] ADDR_CH0_REF_LEVEL = 16'hf952;
   localparam logic [15:0] ADDR_CH1_CONTROL   = 16'hf954;
   localparam logic [15:0] ADDR_CH1_INT_SETUP = 16'hf955;
   localparam logic [15:0] ADDR_CH1_REF_LEVEL = 16'hf956;
   localparam logic [15:0] ADDR_IRQ_STATUS    = 16'hf958;
   localparam logic [15:0] ADDR_IRQ_MASK      = 16'hf959;
   // field positions
   localparam int POS_POWER_ON   = 0;
   localparam int POS_RESULT     = 1;
   localparam int POS_EDGE_LO    = 0;
   localparam int POS_SAMPLE_LO  = 2;
   localparam int POS_REF_SOURCE = 4;
   // reset values
   localparam logic [7:0] RST_CONTROL   = 8'h00;
   localparam logic [7:0] RST_INT_SETUP = 8'h00;
   localparam logic [7:0] RST_REF_LEVEL = 8'h08;
   localparam logic [1:0] RST_MASK      = 2'h0;
   // edge modes
   localparam logic [1:0] EDGE_OFF  = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // sampling selections
   localparam logic [1:0] SMP_NONE = 2'h0;
   localparam logic [1:0] SMP_16K  = 2'h1;
   localparam logic [1:0] SMP_128K = 2'h2;
   localparam logic [1:0] SMP_256K = 2'h3;
   // tick timing
   localparam int CLK_HZ      = 100000000;
   localparam int TICK_256K_HZ = 256000;
   localparam int DIV_256K    = CLK_HZ / TICK_256K_HZ;
   localparam logic [8:0] DIV_256K_LAST = 9'(DIV_256K - 1);
   localparam int SETTLE_MS   = 3;
endpackage
`default_nettype wire

// ===== logic/dcc_top.sv
// dual comparator control: registers, result hold, sampling and edge interrupts
//
// Summary of operation
// - two independent channels, each with enable, result, edge, sampling, reference controls.
// - channel 0 control bit 0 powers comparator 0; resets to 0.
// - channel 1 control bit 0 powers comparator 1; resets to 0.
// - channel 0 control bit 1 reads comparator 0 output; resets to 0.
// - channel 1 control bit 1 reads input above internal reference; resets to 0.
// - disabled channel keeps its last result flag value.
// - interrupt setup bits 1:0 select off, falling, rising or both edges.
// - interrupt request on matching edge only, never when mode is off.
// - interrupt setup bits 3:2 select no sampling or 16k, 128k, 256k tick.
// - in stop mode ticks halt, so no tick-based sampling happens; sampling field 0 still follows the input every clock.
// - channel 0 setup bit 4 selects internal or external reference.
// - reference level bits 3:0 pick 0.05 V steps, reset code 8.
// - channel 0 level code applies only while the internal reference is selected; channel 1 level code always applies.
// - control and setup reset to 00h, reference level to 08h.
// - each channel has its own interrupt request line.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module dcc_top (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        clk_en_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   input  wire logic [1:0]  comp_out_i,
   input  wire logic        stop_mode_i,
   output logic      [1:0]  power_on_o,
   output logic             ref_external_o,
   output logic      [3:0]  level_code0_o,
   output logic      [3:0]  level_code1_o,
   output logic      [1:0]  channel_interrupt_request_o,
   output logic             irq_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // register state
   logic [1:0] power_on_r;
   logic [1:0] edge_mode_r [2];
   logic [1:0] sample_sel_r [2];
   logic       ref_source_r;
   logic [3:0] level_code_r [2];
   logic [1:0] result_r;
   logic [1:0] sync1_r;
   logic [1:0] sync2_r;
   logic [1:0] level_r;
   logic [1:0] level_prev_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic [8:0] div_cnt_r;
   logic [3:0] div_256k_r;
   logic       tick_16k;
   logic       tick_128k;
   logic       tick_256k;
   logic [1:0] edge_hit;
   logic [1:0] sample_now;

   ////////////////////////////////////////////////////////////////////////////////
   // tick generation: 256k base, divided by 2 and 16; halted in stop mode
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt_r  <= 9'h000;
         div_256k_r <= 4'h0;
      end else if (clk_en_i && !stop_mode_i) begin
         if (div_cnt_r == dcc_pkg::DIV_256K_LAST) begin
            div_cnt_r  <= 9'h000;
            div_256k_r <= div_256k_r + 4'h1;
         end else begin
            div_cnt_r <= div_cnt_r + 9'h001;
         end
      end
   end

   // one-cycle tick strobes
   assign tick_256k = clk_en_i && !stop_mode_i && (div_cnt_r == dcc_pkg::DIV_256K_LAST);
   assign tick_128k = tick_256k && div_256k_r[0];
   assign tick_16k  = tick_256k && (div_256k_r == 4'hf);

   ////////////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power_on_r      <= 2'h0;
         edge_mode_r[0]  <= dcc_pkg::RST_INT_SETUP[1:0];
         edge_mode_r[1]  <= dcc_pkg::RST_INT_SETUP[1:0];
         sample_sel_r[0] <= dcc_pkg::RST_INT_SETUP[3:2];
         sample_sel_r[1] <= dcc_pkg::RST_INT_SETUP[3:2];
         ref_source_r    <= dcc_pkg::RST_INT_SETUP[4];
         level_code_r[0] <= dcc_pkg::RST_REF_LEVEL[3:0];
         level_code_r[1] <= dcc_pkg::RST_REF_LEVEL[3:0];
         irq_mask_r      <= dcc_pkg::RST_MASK;
      end else if (clk_en_i && wr_i) begin
         case (addr_i)
            dcc_pkg::ADDR_CH0_CONTROL: power_on_r[0] <= wdata_i[dcc_pkg::POS_POWER_ON];
            dcc_pkg::ADDR_CH1_CONTROL: power_on_r[1] <= wdata_i[dcc_pkg::POS_POWER_ON];
            dcc_pkg::ADDR_CH0_INT_SETUP: begin
               edge_mode_r[0]  <= wdata_i[1:0];
               sample_sel_r[0] <= wdata_i[3:2];
               ref_source_r    <= wdata_i[dcc_pkg::POS_REF_SOURCE];
            end
            dcc_pkg::ADDR_CH1_INT_SETUP: begin
               edge_mode_r[1]  <= wdata_i[1:0];
               sample_sel_r[1] <= wdata_i[3:2];
            end
            dcc_pkg::ADDR_CH0_REF_LEVEL: level_code_r[0] <= wdata_i[3:0];
            dcc_pkg::ADDR_CH1_REF_LEVEL: level_code_r[1] <= wdata_i[3:0];
            dcc_pkg::ADDR_IRQ_MASK:      irq_mask_r      <= wdata_i[1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // per-channel synchroniser, sampling, result hold and edge detect
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         // sampling strobe chosen by the sampling field
         always_comb begin
            case (sample_sel_r[ch])
               dcc_pkg::SMP_NONE: sample_now[ch] = clk_en_i;
               dcc_pkg::SMP_16K:  sample_now[ch] = tick_16k;
               dcc_pkg::SMP_128K: sample_now[ch] = tick_128k;
               dcc_pkg::SMP_256K: sample_now[ch] = tick_256k;
               default:           sample_now[ch] = 1'b0;
            endcase
         end

         // two-stage synchroniser for the analog output
         always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               sync1_r[ch] <= 1'b0;
               sync2_r[ch] <= 1'b0;
            end else if (clk_en_i) begin
               sync1_r[ch] <= comp_out_i[ch];
               sync2_r[ch] <= sync1_r[ch];
            end
         end

         // detected level follows input only while powered and on the strobe
         always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               level_r[ch]      <= 1'b0;
               level_prev_r[ch] <= 1'b0;
               result_r[ch]     <= 1'b0;
            end else if (clk_en_i) begin
               level_prev_r[ch] <= level_r[ch];
               if (power_on_r[ch] && sample_now[ch]) begin
                  level_r[ch]  <= sync2_r[ch];
                  result_r[ch] <= sync2_r[ch];
               end
            end
         end

         // edge match against the selected mode
         always_comb begin
            case (edge_mode_r[ch])
               dcc_pkg::EDGE_FALL: edge_hit[ch] = level_prev_r[ch] && !level_r[ch];
               dcc_pkg::EDGE_RISE: edge_hit[ch] = !level_prev_r[ch] && level_r[ch];
               dcc_pkg::EDGE_BOTH: edge_hit[ch] = level_prev_r[ch] != level_r[ch];
               default:            edge_hit[ch] = 1'b0;
            endcase
         end

         // per-channel one-cycle request line
         always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               channel_interrupt_request_o[ch] <= 1'b0;
            end else if (clk_en_i) begin
               channel_interrupt_request_o[ch] <= edge_hit[ch];
            end
         end

         // sticky status, set wins over write-one clear
         always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               irq_stat_r[ch] <= 1'b0;
            end else if (clk_en_i) begin
               if (edge_hit[ch]) begin
                  irq_stat_r[ch] <= 1'b1;
               end else if (wr_i && addr_i == dcc_pkg::ADDR_IRQ_STATUS && wdata_i[ch]) begin
                  irq_stat_r[ch] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // analog-side controls and interrupt output
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power_on_o     <= 2'h0;
         ref_external_o <= 1'b0;
         level_code0_o  <= dcc_pkg::RST_REF_LEVEL[3:0];
         level_code1_o  <= dcc_pkg::RST_REF_LEVEL[3:0];
         irq_o          <= 1'b0;
      end else if (clk_en_i) begin
         power_on_o     <= power_on_r;
         ref_external_o <= ref_source_r;
         // channel 0 level code driven only while internal reference in use, else reset code 8; channel 1 always driven
         level_code0_o  <= ref_source_r ? dcc_pkg::RST_REF_LEVEL[3:0] : level_code_r[0];
         level_code1_o  <= level_code_r[1];
         irq_o          <= |(irq_stat_r & irq_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (clk_en_i) begin
         if (rd_i) begin
            case (addr_i)
               dcc_pkg::ADDR_CH0_CONTROL:   rdata_o <= {6'h00, result_r[0], power_on_r[0]};
               dcc_pkg::ADDR_CH1_CONTROL:   rdata_o <= {6'h00, result_r[1], power_on_r[1]};
               dcc_pkg::ADDR_CH0_INT_SETUP:
                  rdata_o <= {3'h0, ref_source_r, sample_sel_r[0], edge_mode_r[0]};
               dcc_pkg::ADDR_CH1_INT_SETUP: rdata_o <= {4'h0, sample_sel_r[1], edge_mode_r[1]};
               dcc_pkg::ADDR_CH0_REF_LEVEL: rdata_o <= {4'h0, level_code_r[0]};
               dcc_pkg::ADDR_CH1_REF_LEVEL: rdata_o <= {4'h0, level_code_r[1]};
               dcc_pkg::ADDR_IRQ_STATUS:    rdata_o <= {6'h00, irq_stat_r};
               dcc_pkg::ADDR_IRQ_MASK:      rdata_o <= {6'h00, irq_mask_r};
               default:                     rdata_o <= 8'h00;
            endcase
         end else begin
            rdata_o <= 8'h00;
         end
      end
   end

endmodule // dcc_top
`default_nettype wire

// ===== verif/dcc_properties.sv
// port timing checker for the dual comparator control
`timescale 1ns/1ns
`default_nettype none
module dcc_properties (
   input wire logic        clk_sys_i,
   input wire logic        rst_n_i,
   input wire logic        clk_en_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0]  wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [7:0]  rdata_o,
   input wire logic [1:0]  power_on_o,
   input wire logic        ref_external_o,
   input wire logic [3:0]  level_code0_o,
   input wire logic [1:0]  channel_interrupt_request_o,
   input wire logic        irq_o
);
   logic [1:0] mode_r;
   logic [1:0] mask_r;
   logic [1:0] pwr_r;
   ////////////////////////////////////////////////////////////////////////////////
   // shadow of edge mode, mask and power bits as software wrote them
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_r <= 2'h0;
         mask_r <= 2'h0;
         pwr_r  <= 2'h0;
      end else if (wr_i && clk_en_i) begin
         if (addr_i == 16'hf951) mode_r <= wdata_i[1:0];
         if (addr_i == 16'hf959) mask_r <= wdata_i[1:0];
         if (addr_i == 16'hf950) pwr_r[0] <= wdata_i[0];
         if (addr_i == 16'hf954) pwr_r[1] <= wdata_i[0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   a_read_data_idle: assert property (
      !($past(rd_i) && $past(clk_en_i)) |-> rdata_o == 8'h00) else $error("read data not idle");
   a_power_follows: assert property (
      power_on_o == $past(pwr_r)) else $error("power output lags wrongly");
   a_mode_off_quiet: assert property (
      mode_r == 2'h0 && $past(mode_r) == 2'h0 |-> !channel_interrupt_request_o[0])
      else $error("request with edge mode off");
   a_off_no_edge: assert property (
      !pwr_r[0] && !$past(pwr_r[0]) && !$past(pwr_r[0], 2) && !$past(pwr_r[0], 3)
      |-> !channel_interrupt_request_o[0]) else $error("request while powered off");
   a_ext_forces_code: assert property (
      ref_external_o |-> level_code0_o == 4'h8) else $error("level code used with external ref");
   a_req_sets_irq: assert property (
      (channel_interrupt_request_o & mask_r) != 2'h0 |=> irq_o) else $error("irq not raised");
   a_masked_irq_low: assert property (
      $past(mask_r) == 2'h0 |-> !irq_o) else $error("irq with all masked");
   a_irq_has_cause: assert property (
      $rose(irq_o) |-> $past(channel_interrupt_request_o) != 2'h0 || $past(wr_i, 2))
      else $error("irq rose without cause");
endmodule // dcc_properties
bind dcc_top dcc_properties u_props (.clk_sys_i, .rst_n_i, .clk_en_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .power_on_o, .ref_external_o, .level_code0_o, .channel_interrupt_request_o,
   .irq_o);
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench of the dual comparator control
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        clk_sys_i   = 1'b0;
   logic        rst_n_i     = 1'b0;
   logic        wr_i        = 1'b0;
   logic        rd_i        = 1'b0;
   logic        stop_mode_i = 1'b0;
   logic [15:0] addr_i      = 16'h0000;
   logic [7:0]  wdata_i     = 8'h00;
   logic [1:0]  comp_out_i  = 2'h0;
   logic [7:0]  rdata_o;
   logic [1:0]  power_on_o, channel_interrupt_request_o;
   logic        ref_external_o, irq_o;
   logic [3:0]  level_code0_o, level_code1_o;
   int          failures = 0, checks = 0, cycles = 0, pulses = 0, p0;
   // rows: address, written byte, byte read back
   logic [31:0] rows [8] = '{32'hf950ff01, 32'hf9511f1f, 32'hf952ff0f, 32'hf954ff01,
                             32'hf955ff0f, 32'hf956ff0f, 32'hf959ff03, 32'hf953ff00};
   logic [63:0] rst_v = 64'h0000_0800_0008_0000;
   dcc_top dut (.clk_sys_i, .rst_n_i, .clk_en_i(1'b1), .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .comp_out_i, .stop_mode_i, .power_on_o, .ref_external_o, .level_code0_o,
      .level_code1_o, .channel_interrupt_request_o, .irq_o);
   ////////////////////////////////////////////////////////////////////////////////
   // clock, request pulse counter and hang limit
   always #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      if (channel_interrupt_request_o[0] === 1'b1) pulses <= pulses + 1;
      cycles++;
      if (cycles == 30000) begin
         failures++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 check(rdata_o, exp);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      tick(20);
      rst_n_i <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i][31:16], rows[i][15:8]);
         rd(rows[i][31:16], rows[i][7:0]);
      end
      $display("register rows done");
      rst_n_i <= 1'b0;
      tick(2);
      rst_n_i <= 1'b1;
      foreach (rows[i]) rd(rows[i][31:16], rst_v[63-8*i -: 8]);
      check({4'h0, level_code1_o}, 8'h08);
      $display("reset values done");
      wr(16'hf950, 8'h01);
      for (int m = 0; m < 4; m++) begin
         wr(16'hf951, 8'(m));
         p0 = pulses;
         @(posedge clk_sys_i) comp_out_i <= 2'h1;
         tick(8);
         check(8'(pulses - p0), 8'(m >> 1));
         p0 = pulses;
         @(posedge clk_sys_i) comp_out_i <= 2'h0;
         tick(8);
         check(8'(pulses - p0), 8'(m & 1));
      end
      $display("edge modes done");
      wr(16'hf959, 8'h01);
      @(posedge clk_sys_i) comp_out_i <= 2'h1;
      tick(8);
      check({7'h0, irq_o}, 8'h01);
      rd(16'hf958, 8'h01);
      wr(16'hf958, 8'h01);
      wr(16'hf959, 8'h00);
      @(posedge clk_sys_i) comp_out_i <= 2'h0;
      tick(8);
      check({7'h0, irq_o}, 8'h00);
      rd(16'hf958, 8'h01);
      wr(16'hf958, 8'h01);
      rd(16'hf958, 8'h00);
      $display("interrupt done");
      wr(16'hf954, 8'h01);
      @(posedge clk_sys_i) comp_out_i <= 2'h3;
      tick(8);
      rd(16'hf950, 8'h03);
      rd(16'hf954, 8'h03);
      wr(16'hf950, 8'h00);
      wr(16'hf954, 8'h00);
      @(posedge clk_sys_i) comp_out_i <= 2'h0;
      tick(8);
      rd(16'hf950, 8'h02);
      rd(16'hf954, 8'h02);
      check({6'h0, power_on_o}, 8'h00);
      wr(16'hf952, 8'h03);
      wr(16'hf951, 8'h10);
      tick(2);
      check({4'h0, level_code0_o}, 8'h08);
      wr(16'hf951, 8'h00);
      tick(2);
      check({4'h0, level_code0_o}, 8'h03);
      $display("hold and reference done");
      @(posedge clk_sys_i) stop_mode_i <= 1'b1;
      wr(16'hf951, 8'h0c);
      wr(16'hf950, 8'h01);
      tick(1200);
      rd(16'hf950, 8'h03);
      @(posedge clk_sys_i) stop_mode_i <= 1'b0;
      tick(1200);
      rd(16'hf950, 8'h01);
      wr(16'hf951, 8'h04);
      @(posedge clk_sys_i) comp_out_i <= 2'h1;
      tick(7000);
      rd(16'hf950, 8'h03);
      $display("sampling done");
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
